// File: rtl/dcr_pkg.sv
// Package: register map, field layout, reset values and state types of the DPLL config bank
package dcr_pkg;

  // ------------------------------------------------------------------
  // Register port geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 16;  // Byte address width
  localparam int DATA_W = 8;   // Byte-wide register port
  localparam int TW_W = 48;    // Free-run tuning word width
  localparam int NUM_BYTES = 28;  // Bytes 0x0300..0x031b
  localparam int IMG_W = NUM_BYTES * DATA_W;
  localparam int IDX_W = 5;    // Byte index inside the bank

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] BANK_BASE = 16'h0300;
  localparam logic [ADDR_W-1:0] FREERUN_TUNING_WORD = 16'h0300;  // Six bytes, LSB first
  localparam logic [ADDR_W-1:0] TUNING_WORD_APPLY = 16'h0306;
  localparam logic [ADDR_W-1:0] PULLIN_LOWER_LIMIT = 16'h0307;
  localparam logic [ADDR_W-1:0] PULLIN_UPPER_LIMIT = 16'h030a;
  localparam logic [ADDR_W-1:0] OPEN_LOOP_PHASE_OFFSET = 16'h030d;
  localparam logic [ADDR_W-1:0] FIXED_LOCK_PHASE_OFFSET = 16'h030f;
  localparam logic [ADDR_W-1:0] PHASE_OFFSET_STEP_SIZE = 16'h0314;
  localparam logic [ADDR_W-1:0] PHASE_SLEW_RATE_LIMIT = 16'h0316;
  localparam logic [ADDR_W-1:0] HISTORY_ACCUM_TIMER = 16'h0318;
  localparam logic [ADDR_W-1:0] HOLDOVER_HISTORY_CONTROL = 16'h031b;

  // ------------------------------------------------------------------
  // Field positions and masks
  // ------------------------------------------------------------------
  localparam int APPLY_BIT = 0;       // Tuning word apply strobe
  localparam int FALLBACK_BIT = 4;    // Single-sample fallback select
  localparam int PERSIST_BIT = 3;     // Persistent history
  localparam logic [7:0] HIST_MODE_MASK = 8'h1f;  // Bits 7:5 unused

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [47:0] FTW_RST = 48'h0;        // 0 Hz free run
  localparam logic [23:0] PULL_LO_RST = 24'h0;
  localparam logic [23:0] PULL_HI_RST = 24'hffffff;  // Full synthesizer range
  localparam logic [15:0] OL_PHASE_RST = 16'h0;
  localparam logic [39:0] FIXED_OFS_RST = 40'h0;
  localparam logic [15:0] STEP_RST = 16'h03e8;    // 1000 ps = 1 ns
  localparam logic [15:0] SLEW_RST = 16'h0;       // Slew limiting off
  localparam logic [23:0] HIST_TIMER_RST = 24'h007530;  // 30000 ms
  localparam logic [7:0] HIST_MODE_RST = 8'h00;

  // ------------------------------------------------------------------
  // Register image, first member is the highest address
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] hist_mode;
    logic [23:0] hist_timer;
    logic [15:0] slew;
    logic [15:0] step;
    logic [39:0] fixed_ofs;
    logic [15:0] ol_phase;
    logic [23:0] pull_hi;
    logic [23:0] pull_lo;
    logic [7:0] apply_pad;  // Strobe byte, never stored
    logic [47:0] ftw;
  } dcr_img_t;

  // Bank state
  typedef struct packed {
    dcr_img_t img;
    logic apply;
    logic [7:0] rdata;
  } dcr_bank_t;

  // Working tuning word state
  typedef struct packed {
    logic [47:0] working;
  } dcr_tw_t;

  // Holdover selection state
  typedef struct packed {
    logic [47:0] hold_tw;
    logic hist_clear;
  } dcr_hold_t;

endpackage

// File: rtl/dcr_cfg_if.sv
// Interface: configuration signals between the register bank and its two helpers
interface dcr_cfg_if;
  import dcr_pkg::*;

  logic [TW_W-1:0] ftw;         // Free-run tuning word register
  logic apply;                  // One-cycle apply pulse
  logic [TW_W-1:0] working_tw;  // Working tuning word
  logic fallback_sel;           // 1: last loop word on missing history
  logic persistent;             // 1: keep history on reference switch

  modport regs (output ftw, output apply, output fallback_sel, output persistent,
    input working_tw);
  modport tw (input ftw, input apply, output working_tw);
  modport hold (input ftw, input fallback_sel, input persistent);
endinterface

// File: rtl/dcr_tw_apply.sv
// Module: working tuning word register inside the tuning word processing logic
module dcr_tw_apply
  import dcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic freerun_mode_i,
  dcr_cfg_if.tw cfg
);

  dcr_tw_t s_q;  // Registered state
  dcr_tw_t s_d;  // Next state

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // In free run the word follows the register without a strobe
    if (cfg.apply || freerun_mode_i) begin
      s_d.working = cfg.ftw;
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q <= '{working: FTW_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign cfg.working_tw = s_q.working;

  AST_WORKING_UPDATE: assert property (@(posedge clock_i) disable iff (reset_i)
    cfg.apply |=> cfg.working_tw == $past(cfg.ftw))
    else $error("Working tuning word missed apply");

endmodule

// File: rtl/dcr_holdover_sel.sv
// Module: holdover tuning word source and history clear on reference switch
module dcr_holdover_sel
  import dcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic holdover_entry_i,
  input wire logic history_valid_i,
  input wire logic [TW_W-1:0] history_tw_i,
  input wire logic [TW_W-1:0] last_loop_tw_i,
  input wire logic ref_switch_i,
  output logic [TW_W-1:0] holdover_tw_o,
  output logic history_clear_o,
  dcr_cfg_if.hold cfg
);

  dcr_hold_t s_q;  // Registered state
  dcr_hold_t s_d;  // Next state

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    // Word is captured once at holdover entry and held until the next
    if (holdover_entry_i) begin
      if (history_valid_i) begin
        s_d.hold_tw = history_tw_i;
      end else if (cfg.fallback_sel) begin
        s_d.hold_tw = last_loop_tw_i;
      end else begin
        s_d.hold_tw = cfg.ftw;
      end
    end
    s_d.hist_clear = ref_switch_i && !cfg.persistent;
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q <= '{hold_tw: FTW_RST, hist_clear: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign holdover_tw_o = s_q.hold_tw;
  assign history_clear_o = s_q.hist_clear;

  AST_HOLD_FALLBACK: assert property (@(posedge clock_i) disable iff (reset_i)
    (holdover_entry_i && !history_valid_i) |=>
      holdover_tw_o == ($past(cfg.fallback_sel) ? $past(last_loop_tw_i) : $past(cfg.ftw)))
    else $error("Holdover word from wrong source");

  AST_HIST_CLEAR: assert property (@(posedge clock_i) disable iff (reset_i)
    ref_switch_i |=> history_clear_o == !$past(cfg.persistent) ##1 !history_clear_o
      || $past(ref_switch_i))
    else $error("History clear does not follow persistent bit");

endmodule

// File: rtl/dcr_config_regs.sv
// Module: DPLL configuration register bank with apply strobe and holdover controls
//
// Behaviour
// - 48-bit free-run word, six bytes, LSB lowest
// - Free-run word resets to zero
// - Apply bit copies word to working register
// - Apply bit clears itself after transfer
// - Pull-in limits 24-bit, reset zero and ones
// - 16-bit open-loop phase offset, reset zero
// - 40-bit fixed lock offset, reset zero
// - 16-bit step size resets to 1000
// - 16-bit slew limit, zero disables limiting
// - 24-bit history timer resets to 30000
// - Missing history uses free-run or loop word
// - Reference switch clears history unless persistent
// - Mode bits 2:0 hold incremental average
module dcr_config_regs
  import dcr_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [DATA_W-1:0] rdata_o,
  input wire logic freerun_mode_i,
  input wire logic holdover_entry_i,
  input wire logic history_valid_i,
  input wire logic [TW_W-1:0] history_tw_i,
  input wire logic [TW_W-1:0] last_loop_tw_i,
  input wire logic ref_switch_i,
  output logic [TW_W-1:0] freerun_tw_o,
  output logic [TW_W-1:0] working_tw_o,
  output logic tw_applied_o,
  output logic [23:0] pullin_lower_o,
  output logic [23:0] pullin_upper_o,
  output logic [15:0] open_loop_phase_o,
  output logic [39:0] fixed_lock_offset_o,
  output logic [15:0] step_size_o,
  output logic [15:0] slew_limit_o,
  output logic slew_limit_en_o,
  output logic [23:0] history_timer_o,
  output logic single_sample_fallback_o,
  output logic persistent_history_o,
  output logic [2:0] incremental_avg_o,
  output logic [TW_W-1:0] holdover_tw_o,
  output logic history_clear_o
);

  // ------------------------------------------------------------------
  // State and decode
  // ------------------------------------------------------------------
  dcr_bank_t s_q;  // Registered bank state
  dcr_bank_t s_d;  // Next bank state
  dcr_cfg_if cfg ();  // Link to the two helpers

  logic in_bank;  // Address falls inside 0x0300..0x031b
  logic [IDX_W-1:0] idx;  // Byte index within the bank
  logic [ADDR_W-1:0] offset;  // Address minus bank base

  // Reset image, kept as one constant so reset and checks agree
  localparam dcr_img_t IMG_RST = '{
    hist_mode: HIST_MODE_RST,
    hist_timer: HIST_TIMER_RST,
    slew: SLEW_RST,
    step: STEP_RST,
    fixed_ofs: FIXED_OFS_RST,
    ol_phase: OL_PHASE_RST,
    pull_hi: PULL_HI_RST,
    pull_lo: PULL_LO_RST,
    apply_pad: 8'h00,
    ftw: FTW_RST
  };

  // Byte index of the two special bytes
  localparam logic [ADDR_W-1:0] APPLY_OFS = TUNING_WORD_APPLY - BANK_BASE;
  localparam logic [ADDR_W-1:0] MODE_OFS = HOLDOVER_HISTORY_CONTROL - BANK_BASE;

  // Address decode, shared by read and write
  always_comb begin
    offset = addr_i - BANK_BASE;
    in_bank = (addr_i >= BANK_BASE) && (addr_i <= HOLDOVER_HISTORY_CONTROL);
    idx = offset[IDX_W-1:0];
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // The bank is held as one flat byte image so every multi-byte field
  // lands LSB first at its lowest address without per-field decode.
  always_comb begin
    logic [IMG_W-1:0] flat;
    logic [7:0] wbyte;
    flat = s_q.img;
    wbyte = wdata_i;
    s_d = s_q;
    // Apply pulse lasts exactly one cycle
    s_d.apply = 1'b0;
    // Read data stand only in the cycle after the strobe
    s_d.rdata = 8'h00;
    if (wr_i && in_bank) begin
      if (offset == APPLY_OFS) begin
        // Strobe byte is not stored, so it never reads back as one
        s_d.apply = wdata_i[APPLY_BIT];
      end else begin
        if (offset == MODE_OFS) begin
          wbyte = wdata_i & HIST_MODE_MASK;
        end
        flat[idx*8 +: 8] = wbyte;
      end
    end
    s_d.img = flat;
    // Unmapped addresses and the strobe byte read as zero
    if (rd_i && in_bank) begin
      s_d.rdata = flat[idx*8 +: 8];
      if (wr_i) begin
        s_d.rdata = s_q.img[idx*8 +: 8];
      end
    end
    // A read in the same cycle as a write returns the old byte; pad byte is kept at zero
    s_d.img.apply_pad = 8'h00;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q <= '{img: IMG_RST, apply: 1'b0, rdata: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rdata_o = s_q.rdata;
  assign freerun_tw_o = s_q.img.ftw;
  assign tw_applied_o = s_q.apply;
  assign pullin_lower_o = s_q.img.pull_lo;
  assign pullin_upper_o = s_q.img.pull_hi;
  assign open_loop_phase_o = s_q.img.ol_phase;
  assign fixed_lock_offset_o = s_q.img.fixed_ofs;
  assign step_size_o = s_q.img.step;
  assign slew_limit_o = s_q.img.slew;
  // A zero rate means the slew limiter is bypassed
  assign slew_limit_en_o = s_q.img.slew != 16'h0000;
  // Zero timer is a software fault and is passed through unchanged
  assign history_timer_o = s_q.img.hist_timer;
  assign single_sample_fallback_o = s_q.img.hist_mode[FALLBACK_BIT];
  assign persistent_history_o = s_q.img.hist_mode[PERSIST_BIT];
  assign incremental_avg_o = s_q.img.hist_mode[2:0];

  // Helper connections
  assign cfg.ftw = s_q.img.ftw;
  assign cfg.apply = s_q.apply;
  assign cfg.fallback_sel = s_q.img.hist_mode[FALLBACK_BIT];
  assign cfg.persistent = s_q.img.hist_mode[PERSIST_BIT];
  assign working_tw_o = cfg.working_tw;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Working register inside the tuning word processing logic
  dcr_tw_apply u_tw_apply (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .freerun_mode_i(freerun_mode_i),
    .cfg(cfg.tw)
  );

  // Holdover source selection and history clearing
  dcr_holdover_sel u_holdover_sel (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .holdover_entry_i(holdover_entry_i),
    .history_valid_i(history_valid_i),
    .history_tw_i(history_tw_i),
    .last_loop_tw_i(last_loop_tw_i),
    .ref_switch_i(ref_switch_i),
    .holdover_tw_o(holdover_tw_o),
    .history_clear_o(history_clear_o),
    .cfg(cfg.hold)
  );

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  AST_RESET_VALUES: assert property (@(posedge clock_i)
    $past(reset_i) && !reset_i |-> freerun_tw_o == FTW_RST && pullin_upper_o == PULL_HI_RST
      && step_size_o == STEP_RST && history_timer_o == HIST_TIMER_RST && !slew_limit_en_o)
    else $error("Bank did not come out of reset at its defaults");

  AST_FTW_TOP_BYTE: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == FREERUN_TUNING_WORD + 16'h0005 |=> freerun_tw_o[47:40] == $past(wdata_i))
    else $error("Top tuning word byte not stored");

  AST_APPLY_PULSE: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == TUNING_WORD_APPLY && wdata_i[APPLY_BIT] |=> tw_applied_o ##1
      (!tw_applied_o || $past(wr_i && addr_i == TUNING_WORD_APPLY)))
    else $error("Apply strobe not a single pulse");

  AST_APPLY_WORKING: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == TUNING_WORD_APPLY && wdata_i[APPLY_BIT] |=> ##1
      working_tw_o == $past(freerun_tw_o))
    else $error("Apply did not reach working register");

  AST_APPLY_READS_ZERO: assert property (@(posedge clock_i) disable iff (reset_i)
    rd_i && addr_i == TUNING_WORD_APPLY |=> rdata_o == 8'h00)
    else $error("Apply byte read back nonzero");

  AST_MODE_UNUSED: assert property (@(posedge clock_i) disable iff (reset_i)
    rd_i && addr_i == HOLDOVER_HISTORY_CONTROL |=> rdata_o[7:5] == 3'b000)
    else $error("Unused history mode bits read back");

  AST_UPPER_LIMIT_WRITE: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == PULLIN_UPPER_LIMIT + 16'h0002 |=>
      pullin_upper_o[23:16] == $past(wdata_i) && pullin_lower_o == $past(pullin_lower_o))
    else $error("Upper pull-in byte misplaced");

  AST_SLEW_DISABLE: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == PHASE_SLEW_RATE_LIMIT && slew_limit_o[15:8] == 8'h00 |=>
      slew_limit_en_o == ($past(wdata_i) != 8'h00))
    else $error("Slew enable does not follow rate");

  AST_AVG_FIELD: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == HOLDOVER_HISTORY_CONTROL |=> incremental_avg_o == $past(wdata_i[2:0])
      && persistent_history_o == $past(wdata_i[PERSIST_BIT]))
    else $error("History mode fields not stored");

  AST_READ_BACK: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_i && addr_i == PHASE_OFFSET_STEP_SIZE ##1 rd_i && addr_i == PHASE_OFFSET_STEP_SIZE
      && !wr_i |=> rdata_o == $past(wdata_i, 2))
    else $error("Step size byte read back wrong");

  AST_UNMAPPED_READ: assert property (@(posedge clock_i) disable iff (reset_i)
    rd_i && (addr_i < BANK_BASE || addr_i > HOLDOVER_HISTORY_CONTROL) |=> rdata_o == 8'h00)
    else $error("Unmapped address read nonzero");

endmodule

// File: verification/tb_dcr_config_regs.sv
// Testbench: self-checking stimulus for the DPLL configuration register bank
module tb_dcr_config_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import dcr_pkg::*;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;  // Held for five cycles at start
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic freerun_mode_i = 1'b0;
  logic holdover_entry_i = 1'b0;
  logic history_valid_i = 1'b0;
  logic [TW_W-1:0] history_tw_i = 48'h1111_2222_3333;
  logic [TW_W-1:0] last_loop_tw_i = 48'h4444_5555_6666;
  logic ref_switch_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [TW_W-1:0] freerun_tw_o, working_tw_o, holdover_tw_o;
  logic tw_applied_o, slew_limit_en_o, single_sample_fallback_o;
  logic persistent_history_o, history_clear_o;
  logic [23:0] pullin_lower_o, pullin_upper_o, history_timer_o;
  logic [15:0] open_loop_phase_o, step_size_o, slew_limit_o;
  logic [39:0] fixed_lock_offset_o;
  logic [2:0] incremental_avg_o;
  int num_errors = 0;
  int n_tests = 0;
  logic [TW_W-1:0] ftw_exp;  // Shadow of the free-run word

  dcr_config_regs dut (.clock_i(clock_i), .reset_i(reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .freerun_mode_i(freerun_mode_i), .holdover_entry_i(holdover_entry_i),
    .history_valid_i(history_valid_i), .history_tw_i(history_tw_i),
    .last_loop_tw_i(last_loop_tw_i), .ref_switch_i(ref_switch_i),
    .freerun_tw_o(freerun_tw_o), .working_tw_o(working_tw_o), .tw_applied_o(tw_applied_o),
    .pullin_lower_o(pullin_lower_o), .pullin_upper_o(pullin_upper_o),
    .open_loop_phase_o(open_loop_phase_o), .fixed_lock_offset_o(fixed_lock_offset_o),
    .step_size_o(step_size_o), .slew_limit_o(slew_limit_o),
    .slew_limit_en_o(slew_limit_en_o), .history_timer_o(history_timer_o),
    .single_sample_fallback_o(single_sample_fallback_o),
    .persistent_history_o(persistent_history_o), .incremental_avg_o(incremental_avg_o),
    .holdover_tw_o(holdover_tw_o), .history_clear_o(history_clear_o));

  // 50 MHz system clock
  initial begin
    forever #10 clock_i = ~clock_i;
  end

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  // Four-state compare, so an unknown never counts as a match
  task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One-cycle write; outputs settle just after the taking edge
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask

  // One-cycle read; data only stands in the following cycle
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk("rdata", {40'h0, exp}, {40'h0, rdata_o});
  endtask

  // Byte pattern for the full sweep, differs in every position
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 59 + 165);
  endfunction

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Every byte reads its documented default after reset
  task automatic t_reset_values();
    logic [223:0] img;
    img = {8'h00, 24'h007530, 16'h0000, 16'h03e8, 40'h0, 16'h0000, 24'hffffff, 24'h000000,
      8'h00, 48'h0};
    for (int i = 0; i < 28; i++) begin
      rd_chk(16'h0300 + 16'(i), img[i*8 +: 8]);
    end
    chk("step", 48'h3e8, 48'(step_size_o));
    chk("slew_en", 48'h0, 48'(slew_limit_en_o));
  endtask

  // Apply strobe copies the word once, then clears itself
  task automatic t_apply();
    ftw_exp = 48'hab89_6745_2301;
    for (int i = 0; i < 6; i++) wr(16'h0300 + 16'(i), ftw_exp[i*8 +: 8]);
    chk("ftw", ftw_exp, freerun_tw_o);
    chk("working_hold", 48'h0, working_tw_o);
    wr(16'h0306, 8'hfe);
    chk("apply_zero", 48'h0, 48'(tw_applied_o));
    wr(16'h0306, 8'h01);
    chk("apply_pulse", 48'h1, 48'(tw_applied_o));
    @(posedge clock_i);
    #1;
    chk("apply_clear", 48'h0, 48'(tw_applied_o));
    chk("working", ftw_exp, working_tw_o);
    rd_chk(16'h0306, 8'h00);
  endtask

  // In free run the working word follows the register without a strobe
  task automatic t_freerun();
    @(posedge clock_i);
    freerun_mode_i <= 1'b1;
    ftw_exp[47:40] = 8'h5a;
    wr(16'h0305, 8'h5a);
    repeat (2) @(posedge clock_i);
    #1;
    chk("freerun_working", ftw_exp, working_tw_o);
    @(posedge clock_i);
    freerun_mode_i <= 1'b0;
  endtask

  // Holdover word source for valid history, then missing history with fallback set and clear
  task automatic hold_pulse(input logic valid, input logic [47:0] exp);
    @(posedge clock_i);
    holdover_entry_i <= 1'b1;
    history_valid_i <= valid;
    @(posedge clock_i);
    holdover_entry_i <= 1'b0;
    #1;
    chk("holdover_tw", exp, holdover_tw_o);
  endtask

  task automatic t_holdover();
    wr(16'h031b, 8'h10);
    hold_pulse(1'b1, history_tw_i);
    hold_pulse(1'b0, last_loop_tw_i);
    wr(16'h031b, 8'h00);
    hold_pulse(1'b0, ftw_exp);
  endtask

  // Reference switch clears history only when not persistent
  task automatic sw_pulse(input logic exp);
    @(posedge clock_i);
    ref_switch_i <= 1'b1;
    @(posedge clock_i);
    ref_switch_i <= 1'b0;
    #1;
    chk("hist_clear", 48'(exp), 48'(history_clear_o));
    @(posedge clock_i);
    #1;
    chk("hist_clear_end", 48'h0, 48'(history_clear_o));
  endtask

  task automatic t_ref_switch();
    sw_pulse(1'b1);
    wr(16'h031b, 8'h08);
    chk("persistent", 48'h1, 48'(persistent_history_o));
    sw_pulse(1'b0);
  endtask

  // Full sweep: write every byte, read back, check outputs and unused bits
  task automatic t_sweep();
    logic [223:0] img;
    for (int i = 0; i < 28; i++) begin
      wr(16'h0300 + 16'(i), pat(i));
      img[i*8 +: 8] = (i == 6) ? 8'h00 : (i == 27) ? (pat(i) & 8'h1f) : pat(i);
    end
    // Writes just outside the bank must leave it untouched
    wr(16'h02ff, 8'h77);
    wr(16'h031c, 8'h77);
    for (int i = 0; i < 28; i++) rd_chk(16'h0300 + 16'(i), img[i*8 +: 8]);
    rd_chk(16'h031c, 8'h00);
    rd_chk(16'h02ff, 8'h00);
    chk("ftw", img[47:0], freerun_tw_o);
    // The sweep also wrote a one to the apply bit
    chk("sweep_working", img[47:0], working_tw_o);
    chk("pull_lo", 48'(img[79:56]), 48'(pullin_lower_o));
    chk("pull_hi", 48'(img[103:80]), 48'(pullin_upper_o));
    chk("ol_phase", 48'(img[119:104]), 48'(open_loop_phase_o));
    chk("fixed", 48'(img[159:120]), 48'(fixed_lock_offset_o));
    chk("step", 48'(img[175:160]), 48'(step_size_o));
    chk("slew", 48'(img[191:176]), 48'(slew_limit_o));
    chk("slew_en", 48'(img[191:176] != 16'h0), 48'(slew_limit_en_o));
    // Timer bytes of the pattern are all nonzero, as software must keep them
    chk("timer", 48'(img[215:192]), 48'(history_timer_o));
    chk("fallback", 48'(img[220]), 48'(single_sample_fallback_o));
    chk("persist", 48'(img[219]), 48'(persistent_history_o));
    chk("avg", 48'(img[218:216]), 48'(incremental_avg_o));
    // Zero slew value turns limiting off again
    wr(16'h0316, 8'h00);
    wr(16'h0317, 8'h00);
    chk("slew_off", 48'h0, 48'(slew_limit_en_o));
  endtask

  // Write then read of one byte with no gap between the strobes
  task automatic t_back_to_back();
    @(posedge clock_i);
    addr_i <= 16'h0314;
    wdata_i <= 8'hc3;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1;
    chk("step_b2b", 48'hc3, 48'(rdata_o));
    @(posedge clock_i);
    #1;
    // Read data stand for one cycle only
    chk("rdata_idle", 48'h0, 48'(rdata_o));
  endtask

  // Reset in mid-run returns the bank and helpers to their defaults
  task automatic t_mid_reset();
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    #1;
    chk("rst_upper", 48'hffffff, 48'(pullin_upper_o));
    chk("rst_timer", 48'h7530, 48'(history_timer_o));
    chk("rst_ftw", 48'h0, freerun_tw_o);
    chk("rst_working", 48'h0, working_tw_o);
    rd_chk(16'h0314, 8'he8);
  endtask

  // ------------------------------------------------------------------
  // Verdict and main sequence
  // ------------------------------------------------------------------
  task automatic test_done();
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200us;
    num_errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    t_reset_values();
    t_apply();
    t_freerun();
    t_holdover();
    t_ref_switch();
    t_sweep();
    t_back_to_back();
    t_mid_reset();
    test_done();
  end
endmodule
